//--- sim/mcs_calc_model.sv
// calculator and test stand stand-in answering each calculation pass
module mcs_calc_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               temp_calc,
  input  wire logic               slow,
  input  wire mcs_pkg::mcs_calc_s res_val,
  output logic                    calc_done,
  output mcs_pkg::mcs_calc_s      calc_res
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  logic       busy;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      busy      <= 1'b0;
      wait_cnt  <= 3'h0;
      calc_done <= 1'b0;
      calc_res  <= '0;
    end
    else
    begin
      calc_done <= 1'b0;
      // stale result inverted every cycle, so it returns every second cycle
      calc_res  <= ~calc_res;
      if (temp_calc)
      begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 3'h5 : 3'h1;
      end
      else if (busy && wait_cnt == 3'h0)
      begin
        busy      <= 1'b0;
        calc_done <= 1'b1;
        calc_res  <= res_val;
      end
      else if (busy)
        wait_cnt <= wait_cnt - 3'h1;
    end
endmodule // mcs_calc_model

//--- sim/test_mcs_top.sv
// self-checking bench for the meter cycle sequencer
`include "mcs_map.svh"
module test_mcs_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 8;
  localparam int PC = 10;
  logic clk = 1'b0, rst_n = 1'b0, key_press_pin = 1'b0, test_short_pin = 1'b0;
  logic unlocked = 1'b0, ai_start = 1'b0, rd_req = 1'b0, rd_fine = 1'b0, rd_interp = 1'b0;
  logic slow = 1'b0;
  logic [2:0] mode_cfg = 3'h6;
  logic [1:0] rd_qty = 2'h0;
  logic [15:0] ai_count = 16'h0000, ai_vol_step = 16'h0007;
  mcs_pkg::mcs_calc_s calc_val = '0, calc_res;
  mcs_pkg::mcs_read_s rd;
  logic calc_done, optical_en, test_mode, display_fine, flow_sample, temp_calc;
  logic ai_active, rd_valid, energy_pulse, volume_pulse, ep, vp, tm_d;
  logic [15:0] sim_vol;
  logic [31:0] heat_energy_total, cooling_energy_total, flow_volume_total;
  logic [31:0] heat_energy_fine, cooling_energy_fine, flow_volume_fine;
  logic [31:0] ehf = '0, ehl = '0, ecf = '0, ecl = '0, evf = '0, evl = '0, inc, pe = '0, pv = '0;
  int n_errors = 0, num_checks = 0, cyc = 0, n_fs = 0, seq_fs = 0, gap = 0, last_fs = 0;
  int n_tc = 0, n_ai = 0, n_ep = 0, n_vp = 0, ew = 0, t0;
  logic [2:0] mc [3] = '{3'h7, 3'h6, 3'h5};
  int ms [3] = '{4, 8, 4};
  int mg [3] = '{4 * TC, 8 * TC, 8 * TC};

  mcs_top #(.TICK_CYC(TC), .PULSE_CYC(PC)) mcs_top_inst (.clk, .rst_n, .key_press_pin,
    .test_short_pin, .mode_cfg, .unlocked, .ai_start, .ai_count, .ai_vol_step, .calc_done,
    .calc_res, .rd_req, .rd_qty, .rd_fine, .rd_interp, .optical_en, .test_mode, .display_fine,
    .flow_sample, .temp_calc, .ai_active, .sim_vol, .heat_energy_total, .cooling_energy_total,
    .flow_volume_total, .heat_energy_fine, .cooling_energy_fine, .flow_volume_fine, .rd_valid,
    .rd, .energy_pulse, .volume_pulse);
  mcs_calc_model mcs_calc_model_inst (.clk, .rst_n, .temp_calc, .slow, .res_val(calc_val),
    .calc_done, .calc_res);

  always #2 clk = ~clk;

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %0h seen %0h", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_tc(input int n);
    int t;
    t = n_tc + n;
    for (int i = 0; i < 5000 && n_tc < t; i++) step(1);
    if (n_tc < t) check("temp_calc count", t, n_tc);
  endtask

  task automatic seq_chk(input int s, input int g);
    wait_tc(3);
    check("samples per sequence", s, seq_fs);
    check("sample spacing", g, gap);
  endtask

  task automatic run_ai(input logic [15:0] n, input logic unl);
    int a0;
    unlocked = unl;
    wait_tc(1);
    step(10);
    a0 = n_ai;
    ai_count = n;
    ai_start = 1'b1;
    step(1);
    ai_start = 1'b0;
    step(1);
    check("ai_active", 1, ai_active);
    check("sim_vol", 16'h0007, sim_vol);
    ai_count = 16'h0001;
    ai_start = 1'b1;
    step(1);
    ai_start = 1'b0;
    for (int i = 0; i < 3000 && ai_active !== 1'b0; i++) step(1);
    check("ai ended", 0, ai_active);
    check("ai integrations", n, n_ai - a0);
    check("fine volume", evf, flow_volume_fine);
    check("legal volume", evl, flow_volume_total);
    check("legal heat", ehl, heat_energy_total);
    check("fine heat", ehf, heat_energy_fine);
  endtask

  function automatic logic [15:0] crc16(input logic [79:0] m);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 79; i >= 0; i--)
      c = (c[15] ^ m[i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction

  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {ehf, ehl, ecf, ecl, evf, evl} = '0;
      tm_d = 1'b0;
    end
    else
    begin
      cyc++;
      if (flow_sample)
      begin
        n_fs++;
        gap = cyc - last_fs;
        last_fs = cyc;
      end
      if (temp_calc)
      begin
        seq_fs = n_fs;
        n_fs = 0;
        n_tc++;
      end
      if (calc_done)
      begin
        inc = ai_active ? 32'(ai_vol_step) : 32'(calc_res.vol);
        n_ai += int'(ai_active);
        ehf += 32'(calc_res.heat);
        ecf += 32'(calc_res.cool);
        evf += inc;
        pe += 32'(calc_res.heat) + 32'(calc_res.cool);
        pv += inc;
        if (!ai_active || unlocked)
        begin
          ehl += 32'(calc_res.heat);
          ecl += 32'(calc_res.cool);
          evl += inc;
        end
      end
      if (energy_pulse && !ep) n_ep++;
      if (volume_pulse && !vp) n_vp++;
      if (energy_pulse) ew++;
      else if (ew != 0)
      begin
        check("pulse width", PC, ew);
        ew = 0;
      end
      if (!test_mode && !tm_d) check("pulse outside test", 0, {energy_pulse, volume_pulse});
      ep = energy_pulse;
      vp = volume_pulse;
      tm_d = test_mode;
    end

  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end

  initial
  begin
    int e0, v0;
    logic [31:0] pe0, pv0, xd;
    step(4);
    rst_n = 1'b1;
    step(1);
    check("optical_en", 0, optical_en);
    check("test_mode", 0, test_mode);
    $display("test reset done");
    key_press_pin = 1'b1;
    t0 = cyc;
    step(2);
    check("optical_en early", 0, optical_en);
    step(3);
    check("optical_en", 1, optical_en);
    key_press_pin = 1'b0;
    seq_chk(4, 2 * TC);
    while (cyc < t0 + 3700) step(1);
    check("optical_en in window", 1, optical_en);
    while (cyc < t0 + 3870) step(1);
    check("optical_en expired", 0, optical_en);
    $display("test optical window done");
    calc_val.vol = 16'h0001;
    foreach (mc[i])
    begin
      mode_cfg = mc[i];
      seq_chk(ms[i], mg[i]);
    end
    calc_val.vol = 16'h0000;
    seq_chk(16, 8 * TC);
    $display("test modes done");
    mode_cfg = 3'h6;
    test_short_pin = 1'b1;
    step(5);
    check("test_mode", 1, test_mode);
    check("display_fine", 1, display_fine);
    seq_chk(8, TC);
    step(600);
    {e0, v0, pe0, pv0} = {n_ep, n_vp, pe, pv};
    calc_val = '{heat: 16'h0002, cool: 16'h0001, vol: 16'h0003};
    wait_tc(4);
    calc_val = '0;
    step(300);
    check("energy pulses", pe - pe0, n_ep - e0);
    check("volume pulses", pv - pv0, n_vp - v0);
    test_short_pin = 1'b0;
    rst_n = 1'b0;
    step(2);
    check("test_mode at restart", 0, test_mode);
    rst_n = 1'b1;
    step(5);
    check("test_mode after restart", 0, test_mode);
    $display("test test mode done");
    mode_cfg = 3'h7;
    calc_val = '{heat: 16'h1388, cool: 16'h0fa0, vol: 16'h0190};
    run_ai(16'h0003, 1'b0);
    slow = 1'b1;
    run_ai(16'h0002, 1'b1);
    $display("test auto integration done");
    wait_tc(1);
    step(10);
    for (int q = 0; q < 3; q++)
      for (int k = 0; k < 3; k++)
      begin
        rd_qty = 2'(q);
        rd_fine = (k == 1);
        rd_interp = (k == 2);
        rd_req = 1'b1;
        step(1);
        rd_req = 1'b0;
        for (int i = 0; i < 4 && rd_valid !== 1'b1; i++) step(1);
        check("rd_valid", 1, rd_valid);
        check("crc", crc16(rd[95:16]), rd.crc);
        xd = (q == 0) ? ((k == 1) ? ehf : ehl / 1000) :
             (q == 1) ? ((k == 1) ? ecf : ecl / 1000) : ((k == 1) ? evf : evl / 100);
        if (k < 2) check("read data", xd, rd.data);
        if (k < 2) check("unit and scale", (q == 2) ? ((k == 1) ? 16'h0382 : 16'h0300) :
          ((k == 1) ? 16'h0100 : 16'h0200), {rd.unit, rd.scale});
        if (k == 2) check("interp not below fine", 1,
          rd.data >= ((q == 0) ? ehf : (q == 1) ? ecf : evf));
        step(1);
      end
    $display("test readout done");
    conclude();
  end
endmodule // test_mcs_top

//--- src/mcs_map.svh
// constants for the meter cycle and test sequencer
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH
`define MCS_CLK_HZ         250000000
`define MCS_TICK_MS        500
`define MCS_TICK_CYC       (`MCS_CLK_HZ / 1000 * `MCS_TICK_MS)
`define MCS_OPT_WIN_MIN    4
`define MCS_OPT_WIN_TICKS  (`MCS_OPT_WIN_MIN * 60 * 1000 / `MCS_TICK_MS)
`define MCS_TEST_HOURS     9
`define MCS_TEST_TICKS     (`MCS_TEST_HOURS * 3600 * 1000 / `MCS_TICK_MS)
`define MCS_PULSE_US       3900
`define MCS_PULSE_CYC      (`MCS_CLK_HZ / 1000000 * `MCS_PULSE_US)
`define MCS_MODE_ADAPT     3'h5
`define MCS_MODE_NORMAL    3'h6
`define MCS_MODE_FAST      3'h7
`define MCS_QTY_HEAT       2'h0
`define MCS_QTY_COOL       2'h1
`define MCS_QTY_VOL        2'h2
`define MCS_E_STD_DIV      32'h0000_03e8
`define MCS_V_STD_DIV      32'h0000_0064
`define MCS_STD_MOD        32'h05f5_e100
`define MCS_UNIT_WH        8'h01
`define MCS_UNIT_KWH       8'h02
`define MCS_UNIT_L         8'h03
`define MCS_SCALE_E0       8'h00
`define MCS_SCALE_EM2      8'h82
`define MCS_CRC_POLY       16'h1021
`endif

//--- src/mcs_pkg.sv
// types for the meter cycle and test sequencer
package mcs_pkg;
  typedef enum logic [2:0] {MCS_SEQ_4T, MCS_SEQ_4K, MCS_SEQ_8, MCS_SEQ_16, MCS_SEQ_32,
                            MCS_SEQ_64} mcs_seq_e;
  typedef enum logic {MCS_IDLE, MCS_AI} mcs_state_e;
  typedef struct packed {
    logic [3:0] spacing;
    logic [4:0] samples;
    logic [2:0] shift;
  } mcs_seq_s;
  typedef struct packed {
    logic [15:0] heat;
    logic [15:0] cool;
    logic [15:0] vol;
  } mcs_calc_s;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] stamp;
    logic [7:0]  unit;
    logic [7:0]  scale;
    logic [15:0] crc;
  } mcs_read_s;
endpackage

//--- src/mcs_pulse.sv
// fixed-width verification pulse train from a pending count
`include "mcs_map.svh"
module mcs_pulse #(
  parameter int unsigned PULSE_CYC = `MCS_PULSE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        add_valid,
  input  wire logic [16:0] add,
  output logic             pulse
);
  logic [31:0] pend;
  logic [31:0] cnt;
  logic        busy;

  // unsent weight carried on, dropped while enable is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend <= '0;
    else if (!enable)
      pend <= '0;
    else
      pend <= pend + (add_valid ? 32'(add) : 32'h0000_0000)
              - ((!busy && pend != '0) ? 32'h0000_0001 : 32'h0000_0000);
  end

  // high for PULSE_CYC, then low for PULSE_CYC + 1
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt   <= '0;
      busy  <= 1'b0;
      pulse <= 1'b0;
    end
    else if (!enable)
    begin
      cnt   <= '0;
      busy  <= 1'b0;
      pulse <= 1'b0;
    end
    else if (!busy)
    begin
      if (pend != '0)
      begin
        busy  <= 1'b1;
        pulse <= 1'b1;
        cnt   <= 32'(PULSE_CYC) - 32'h0000_0001;
      end
    end
    else if (cnt != '0)
      cnt <= cnt - 32'h0000_0001;
    else if (pulse)
    begin
      pulse <= 1'b0;
      cnt   <= 32'(PULSE_CYC) - 32'h0000_0001;
    end
    else
      busy <= 1'b0;
  end
endmodule // mcs_pulse

//--- src/mcs_timer.sv
// retriggerable timeout counted in timebase ticks
module mcs_timer #(
  parameter int W = 17
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic [W-1:0] limit,
  output logic              active
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (start)
      cnt <= limit;
    else if (tick && cnt != '0)
      cnt <= cnt - W'(1);
  end

  assign active = (cnt != '0);
endmodule // mcs_timer

//--- src/mcs_top.sv
// meter cycle sequencer with test mode, auto-integration and fine readout
// Summary of operation
// - optical data enabled only four minutes after the latest key press
// - integration mode code 5 adaptive, 6 normal, 7 fast picks cycle times
// - test: 4 s, eight samples each 0.5 s; key mode: four at 1 s
// - slower: 8 s four at 2 s; 16, 32, 64 s sampling every 4 s
// - temperature and calculations once per sequence after its flow samples
// - shorted test points enter test mode regardless of configured mode
// - test mode ends at restart or after nine hours
// - test mode shows energies and volume at fine resolution
// - auto-integration adds equal simulated volume steps, energy from measured temps
// - serial command starts auto-integration; device flags it on receipt, first step at next sequence's calculation
// - locked device keeps auto-integration out of legal totals
// - fine volume in 10 mL, energy in Wh, readable by display and serial
// - flying read returns interpolated fine value with time stamp
// - serial read offers standard eight-digit value or fine register
// - verification pulses only in test mode
// - each verification pulse 3.9 ms wide
// - 1000 pulses per kWh, 100 pulses per litre
// - each returned value carries time stamp, unit, scale and CRC16
`include "mcs_map.svh"
module mcs_top #(
  parameter int unsigned TICK_CYC  = `MCS_TICK_CYC,
  parameter int unsigned PULSE_CYC = `MCS_PULSE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               key_press_pin,
  input  wire logic               test_short_pin,
  input  wire logic [2:0]         mode_cfg,
  input  wire logic               unlocked,
  input  wire logic               ai_start,
  input  wire logic [15:0]        ai_count,
  input  wire logic [15:0]        ai_vol_step,
  input  wire logic               calc_done,
  input  wire mcs_pkg::mcs_calc_s calc_res,
  input  wire logic               rd_req,
  input  wire logic [1:0]         rd_qty,
  input  wire logic               rd_fine,
  input  wire logic               rd_interp,
  output logic                    optical_en,
  output logic                    test_mode,
  output logic                    display_fine,
  output logic                    flow_sample,
  output logic                    temp_calc,
  output logic                    ai_active,
  output logic [15:0]             sim_vol,
  output logic [31:0]             heat_energy_total,
  output logic [31:0]             cooling_energy_total,
  output logic [31:0]             flow_volume_total,
  output logic [31:0]             heat_energy_fine,
  output logic [31:0]             cooling_energy_fine,
  output logic [31:0]             flow_volume_fine,
  output logic                    rd_valid,
  output mcs_pkg::mcs_read_s      rd,
  output logic                    energy_pulse,
  output logic                    volume_pulse
);
  logic [2:0]           key_s;
  logic [2:0]           tst_s;
  logic                 key_rise;
  logic                 tst_rise;
  logic [31:0]          pre_cnt;
  logic                 tick;
  logic [31:0]          ts;
  logic                 win_active;
  logic                 tst_active;
  mcs_pkg::mcs_seq_s    cfg;
  logic [3:0]           spc_cnt;
  logic [4:0]           smp_cnt;
  logic [7:0]           elapsed;
  logic                 seq_end;
  logic                 flow_seen;
  mcs_pkg::mcs_state_e  state;
  logic [15:0]          ai_left;
  logic                 calc_is_ai;
  logic [15:0]          vol_step;
  logic                 legal_ok;
  logic [15:0]          last_heat;
  logic [15:0]          last_cool;
  logic [15:0]          last_vol;
  logic [31:0]          int_stamp;
  logic [31:0]          sel_fine;
  logic [31:0]          sel_total;
  logic [15:0]          sel_last;
  mcs_pkg::mcs_read_s   next_rd;

  function automatic mcs_pkg::mcs_seq_s seq_of(input mcs_pkg::mcs_seq_e s);
    case (s)
      mcs_pkg::MCS_SEQ_4T: seq_of = '{spacing: 4'h1, samples: 5'h08, shift: 3'h3};
      mcs_pkg::MCS_SEQ_4K: seq_of = '{spacing: 4'h2, samples: 5'h04, shift: 3'h3};
      mcs_pkg::MCS_SEQ_8:  seq_of = '{spacing: 4'h4, samples: 5'h04, shift: 3'h4};
      mcs_pkg::MCS_SEQ_16: seq_of = '{spacing: 4'h8, samples: 5'h04, shift: 3'h5};
      mcs_pkg::MCS_SEQ_32: seq_of = '{spacing: 4'h8, samples: 5'h08, shift: 3'h6};
      default:             seq_of = '{spacing: 4'h8, samples: 5'h10, shift: 3'h7};
    endcase
  endfunction

  function automatic mcs_pkg::mcs_seq_e pick(input logic tm, input logic key,
                                              input logic [2:0] mode, input logic flow);
    if (tm)
      pick = mcs_pkg::MCS_SEQ_4T;
    else if (key)
      pick = mcs_pkg::MCS_SEQ_4K;
    else if (mode == `MCS_MODE_FAST)
      pick = mcs_pkg::MCS_SEQ_8;
    else if (mode == `MCS_MODE_ADAPT)
      pick = flow ? mcs_pkg::MCS_SEQ_16 : mcs_pkg::MCS_SEQ_64;
    else
      pick = mcs_pkg::MCS_SEQ_32;
  endfunction

  function automatic logic [15:0] crc16(input logic [79:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 79; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `MCS_CRC_POLY : 16'h0000);
    crc16 = c;
  endfunction

  assign key_rise = key_s[1] & ~key_s[2];
  assign tst_rise = tst_s[1] & ~tst_s[2];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_s <= '0;
      tst_s <= '0;
    end
    else
    begin
      key_s <= {key_s[1:0], key_press_pin};
      tst_s <= {tst_s[1:0], test_short_pin};
    end
  end

  // half-second timebase and time stamp
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt <= '0;
      tick    <= 1'b0;
      ts      <= '0;
    end
    else
    begin
      tick    <= (pre_cnt == 32'(TICK_CYC) - 32'h0000_0001);
      pre_cnt <= (pre_cnt == 32'(TICK_CYC) - 32'h0000_0001) ? '0 : pre_cnt + 32'h0000_0001;
      ts      <= ts + (tick ? 32'h0000_0001 : 32'h0000_0000);
    end
  end

  mcs_timer #(.W(17)) u_win (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick   (tick),
    .start  (key_rise),
    .limit  (17'(`MCS_OPT_WIN_TICKS)),
    .active (win_active)
  );

  mcs_timer #(.W(17)) u_test (
    .clk    (clk),
    .rst_n  (rst_n),
    .tick   (tick),
    .start  (tst_rise),
    .limit  (17'(`MCS_TEST_TICKS)),
    .active (tst_active)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      optical_en   <= 1'b0;
      test_mode    <= 1'b0;
      display_fine <= 1'b0;
    end
    else
    begin
      optical_en   <= win_active;
      test_mode    <= tst_active;
      display_fine <= tst_active;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg         <= seq_of(mcs_pkg::MCS_SEQ_32);
      spc_cnt     <= '0;
      smp_cnt     <= '0;
      elapsed     <= '0;
      seq_end     <= 1'b0;
      flow_sample <= 1'b0;
      temp_calc   <= 1'b0;
    end
    else
    begin
      flow_sample <= 1'b0;
      seq_end     <= 1'b0;
      temp_calc   <= seq_end;
      if (seq_end)
        cfg <= seq_of(pick(test_mode, optical_en, mode_cfg, flow_seen));
      if (tick)
      begin
        elapsed <= elapsed + 8'h01;
        if (spc_cnt == cfg.spacing - 4'h1)
        begin
          spc_cnt     <= '0;
          flow_sample <= 1'b1;
          if (smp_cnt == cfg.samples - 5'h01)
          begin
            smp_cnt <= '0;
            elapsed <= '0;
            seq_end <= 1'b1;
          end
          else
            smp_cnt <= smp_cnt + 5'h01;
        end
        else
          spc_cnt <= spc_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= mcs_pkg::MCS_IDLE;
      ai_active  <= 1'b0;
      ai_left    <= '0;
      sim_vol    <= '0;
      calc_is_ai <= 1'b0;
    end
    else
    begin
      if (temp_calc)
        calc_is_ai <= (state == mcs_pkg::MCS_AI);
      case (state)
        mcs_pkg::MCS_IDLE:
          if (ai_start && ai_count != '0)
          begin
            state     <= mcs_pkg::MCS_AI;
            ai_active <= 1'b1;
            ai_left   <= ai_count;
            sim_vol   <= ai_vol_step;
          end
        mcs_pkg::MCS_AI:
          if (calc_done && calc_is_ai)
          begin
            ai_left <= ai_left - 16'h0001;
            if (ai_left == 16'h0001)
            begin
              state     <= mcs_pkg::MCS_IDLE;
              ai_active <= 1'b0;
            end
          end
        default:
          state <= mcs_pkg::MCS_IDLE;
      endcase
    end
  end

  assign vol_step = calc_is_ai ? sim_vol : calc_res.vol;
  assign legal_ok = !(calc_is_ai && !unlocked);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      heat_energy_fine     <= '0;
      cooling_energy_fine  <= '0;
      flow_volume_fine     <= '0;
      heat_energy_total    <= '0;
      cooling_energy_total <= '0;
      flow_volume_total    <= '0;
      last_heat            <= '0;
      last_cool            <= '0;
      last_vol             <= '0;
      int_stamp            <= '0;
      flow_seen            <= 1'b0;
    end
    else if (calc_done)
    begin
      heat_energy_fine    <= heat_energy_fine + 32'(calc_res.heat);
      cooling_energy_fine <= cooling_energy_fine + 32'(calc_res.cool);
      flow_volume_fine    <= flow_volume_fine + 32'(vol_step);
      if (legal_ok)
      begin
        heat_energy_total    <= heat_energy_total + 32'(calc_res.heat);
        cooling_energy_total <= cooling_energy_total + 32'(calc_res.cool);
        flow_volume_total    <= flow_volume_total + 32'(vol_step);
      end
      last_heat <= calc_res.heat;
      last_cool <= calc_res.cool;
      last_vol  <= vol_step;
      int_stamp <= ts;
      flow_seen <= (calc_res.vol != '0);
    end
  end

  always_comb
  begin
    case (rd_qty)
      `MCS_QTY_HEAT:
      begin
        sel_fine  = heat_energy_fine;
        sel_total = heat_energy_total;
        sel_last  = last_heat;
      end
      `MCS_QTY_COOL:
      begin
        sel_fine  = cooling_energy_fine;
        sel_total = cooling_energy_total;
        sel_last  = last_cool;
      end
      default:
      begin
        sel_fine  = flow_volume_fine;
        sel_total = flow_volume_total;
        sel_last  = last_vol;
      end
    endcase
    if (rd_interp)
    begin
      next_rd.data  = sel_fine + 32'((40'(sel_last) * 40'(elapsed)) >> cfg.shift);
      next_rd.stamp = ts;
    end
    else if (rd_fine)
    begin
      next_rd.data  = sel_fine;
      next_rd.stamp = int_stamp;
    end
    else
    begin
      next_rd.data  = (sel_total / ((rd_qty == `MCS_QTY_VOL) ? `MCS_V_STD_DIV : `MCS_E_STD_DIV))
                      % `MCS_STD_MOD;
      next_rd.stamp = int_stamp;
    end
    if (rd_qty == `MCS_QTY_VOL)
    begin
      next_rd.unit  = `MCS_UNIT_L;
      next_rd.scale = (rd_interp || rd_fine) ? `MCS_SCALE_EM2 : `MCS_SCALE_E0;
    end
    else
    begin
      next_rd.unit  = (rd_interp || rd_fine) ? `MCS_UNIT_WH : `MCS_UNIT_KWH;
      next_rd.scale = `MCS_SCALE_E0;
    end
    next_rd.crc = crc16({next_rd.data, next_rd.stamp, next_rd.unit, next_rd.scale});
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      rd       <= '0;
    end
    else
    begin
      rd_valid <= rd_req;
      if (rd_req)
        rd <= next_rd;
    end
  end

  // one pulse per Wh and per 10 mL
  mcs_pulse #(.PULSE_CYC(PULSE_CYC)) u_epulse (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (test_mode),
    .add_valid (calc_done),
    .add       (17'(calc_res.heat) + 17'(calc_res.cool)),
    .pulse     (energy_pulse)
  );

  mcs_pulse #(.PULSE_CYC(PULSE_CYC)) u_vpulse (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (test_mode),
    .add_valid (calc_done),
    .add       (17'(vol_step)),
    .pulse     (volume_pulse)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_opt_win;  key_rise |-> ##2 optical_en; endproperty
  a_opt_win: assert property (p_opt_win) else $error("optical window not opened");
  property p_test_in;  tst_rise |-> ##2 test_mode; endproperty
  a_test_in: assert property (p_test_in) else $error("test mode not entered");
  property p_test_out; $fell(test_mode) |-> $past(tick, 2); endproperty
  a_test_out: assert property (p_test_out) else $error("test mode left off tick");
  property p_calc_after; temp_calc |-> $past(flow_sample) && !flow_sample; endproperty
  a_calc_after: assert property (p_calc_after) else $error("calc not after samples");
  property p_calc_test; seq_end && test_mode |=> cfg.samples == 5'h08
    && cfg.spacing == 4'h1; endproperty
  a_calc_test: assert property (p_calc_test) else $error("test sequence length wrong");
  property p_pulse_off; !test_mode |=> !energy_pulse && !volume_pulse; endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("pulse outside test mode");
  property p_pulse_w; $rose(energy_pulse) |-> (energy_pulse[*8] or ##[0:7] !test_mode);
  endproperty
  a_pulse_w: assert property (p_pulse_w) else $error("pulse too short");
  property p_legal; calc_done && calc_is_ai && !unlocked |=> $stable(flow_volume_total)
    && $stable(heat_energy_total); endproperty
  a_legal: assert property (p_legal) else $error("locked run touched legal totals");
  property p_ai_step; calc_done && calc_is_ai |=>
    flow_volume_fine == $past(flow_volume_fine) + 32'($past(sim_vol)); endproperty
  a_ai_step: assert property (p_ai_step) else $error("simulated step not added");
  property p_ai_go; state == mcs_pkg::MCS_IDLE && ai_start && ai_count != '0 |=> ai_active;
  endproperty
  a_ai_go: assert property (p_ai_go) else $error("auto-integration not started");
  property p_rd; rd_req |=> rd_valid && rd.crc == crc16({rd.data, rd.stamp, rd.unit, rd.scale});
  endproperty
  a_rd: assert property (p_rd) else $error("read answer bad");
  c_test: cover property (tst_rise ##2 test_mode);
  c_ai: cover property (ai_active ##1 !ai_active);
  c_pulse: cover property ($rose(energy_pulse));
  c_interp: cover property (rd_req && rd_interp ##1 rd_valid);
endmodule // mcs_top
